// ===== hw/irrb_pkg.sv
// interrupt request register bank: shared constants and carrier types
// assumes one system clock and a plain special-register port on the cpu side

package irrb_pkg;

  // ---------------------------------------------------------------
  // register indices on the special-register port
  // ---------------------------------------------------------------
  localparam int         NUM_REGS = 8;
  localparam int         ADDR_W   = 3;
  localparam logic [2:0] IDX_EDGE = 3'h0;
  localparam logic [2:0] IDX_PRI0 = 3'h1;
  localparam logic [2:0] IDX_PRI1 = 3'h2;
  localparam logic [2:0] IDX_PRI2 = 3'h3;
  localparam logic [2:0] IDX_PRI3 = 3'h4;
  localparam logic [2:0] IDX_GRP0 = 3'h5;
  localparam logic [2:0] IDX_GRP1 = 3'h6;
  localparam logic [2:0] IDX_GRP2 = 3'h7;

  // ---------------------------------------------------------------
  // implemented bits and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] IMPL_MASK [0:NUM_REGS-1] = '{
    8'h0f, 8'h7f, 8'hff, 8'hff, 8'h33, 8'hff, 8'hff, 8'h33};
  localparam logic [7:0] RESET_VAL = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int         FLAG_LSB     = 4;
  localparam int         FIELD_W      = 4;
  localparam int         GIE_BIT      = 0;
  localparam int         PIN0_SEL_LSB = 0;
  localparam int         PIN1_SEL_LSB = 2;
  localparam logic [7:0] FLAG_MASK    = 8'hf0;

  // edge select codes
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ---------------------------------------------------------------
  // primary sources, in priority order (index 0 highest)
  // ---------------------------------------------------------------
  localparam int NUM_SRC  = 13;
  localparam int VEC_W    = 4;
  localparam int V_PIN0   = 0;
  localparam int V_PIN1   = 1;
  localparam int V_ADC    = 2;
  localparam int V_GRP0   = 3;
  localparam int V_GRP1   = 4;
  localparam int V_GRP2   = 5;
  localparam int V_OVP    = 6;
  localparam int V_TB0    = 7;
  localparam int V_TB1    = 8;
  localparam int V_UART0  = 9;
  localparam int V_SIM    = 10;
  localparam int V_SPIA   = 11;
  localparam int V_UART1  = 12;
  // holding register, enable bit and flag bit of each source
  localparam logic [2:0] SRC_REG [0:NUM_SRC-1] = '{
    3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h2,
    3'h3, 3'h3, 3'h3, 3'h3, 3'h4, 3'h4};
  localparam logic [1:0] SRC_BIT [0:NUM_SRC-1] = '{
    2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h3,
    2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1};
  // primary 0 flags sit three above their enables, the others four
  localparam logic [2:0] SRC_FLAG [0:NUM_SRC-1] = '{
    3'h4, 3'h5, 3'h6, 3'h4, 3'h5, 3'h6, 3'h7,
    3'h4, 3'h5, 3'h6, 3'h7, 3'h4, 3'h5};

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic adc;
    logic ovp;
    logic tb0;
    logic tb1;
    logic uart0;
    logic sim;
    logic spia;
    logic uart1;
  } irrb_pri_evt_s;

  typedef struct packed {
    logic [3:0] grp2;
    logic [3:0] grp1;
    logic [3:0] grp0;
  } irrb_grp_evt_s;

endpackage

// ===== hw/irrb_top.sv
// interrupt request register bank: flags, enables, edge select, vector request
// assumes event pulses and cpu strobes on CLK; pins arrive asynchronous
//
// Overview of operation
// - only two external pins, 0 and 1; all other sources are internal.
// - four primary control registers, three grouped registers, one edge-select register.
// - each grouped register holds flags and enables sharing one group vector.
// - pin 1 edge code in bits 3:2: off, rising, falling, both.
// - pin 0 edge code in bits 1:0, same coding as pin 1.
// - edge-select bits 7:4 read zero; edge fields reset to zero.
// - primary register 0 bit 7 reads zero; other bits reset zero.
// - converter request flag sits at primary register 0 bit 6.
// - pin 1 and pin 0 flags at bits 5, 4, set on selected edge.
// - converter, pin 1, pin 0 enables at bits 3, 2, 1.
// - global enable at primary register 0 bit 0 gates every request.
// - primary register 1: over-voltage flag bit 7, group 2..0 flags bits 6..4.
// - primary register 1: over-voltage enable bit 3, group 2..0 enables 2..0.
// - primary register 2 flags: serial module, uart0, timebase1, timebase0 at 7..4.
// - primary register 2 enables: same sources at bits 3..0.
// - primary register 3: uart1, port A flags 5,4; enables 1,0; rest unused.
// - every flag and enable is software read/write, zero after reset.
// - set flag requests its vector only while its enable is one.
// - taking an interrupt clears global enable; flags still latch meanwhile.
// - no request is raised while the return stack is full.
// - a flag newly set wakes the device; an already set flag does not.

`timescale 1ns/1ps
`default_nettype none

module irrb_top #(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic                   CLK,
  input  wire logic                   RST,
  input  wire logic                   CE,
  input  wire logic [2:0]             SFR_ADDR,
  input  wire logic                   SFR_WR,
  input  wire logic [7:0]             SFR_WDATA,
  output logic      [7:0]             SFR_RDATA,
  input  wire logic                   PIN0,
  input  wire logic                   PIN1,
  input  wire irrb_pkg::irrb_pri_evt_s PRI_EVT,
  input  wire irrb_pkg::irrb_grp_evt_s GRP_EVT,
  input  wire logic                   STACK_FULL,
  input  wire logic                   IRQ_ACK,
  output logic                        IRQ_REQ,
  output logic      [3:0]             IRQ_VEC,
  output logic                        WAKE
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least 2");
  end
  if (irrb_pkg::NUM_SRC > (2 ** irrb_pkg::VEC_W)) begin : g_bad_vec
    $error("source count exceeds the vector width");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // edge coding
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic       cur,
                                    input logic       prev);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = ~cur & prev;
    unique case (sel)
      irrb_pkg::EDGE_OFF:  edge_hit = 1'b0;
      irrb_pkg::EDGE_RISE: edge_hit = rise;
      irrb_pkg::EDGE_FALL: edge_hit = fall;
      irrb_pkg::EDGE_BOTH: edge_hit = rise | fall;
    endcase
  endfunction

  // lowest index wins
  function automatic logic [3:0] first_pending(
      input logic [irrb_pkg::NUM_SRC-1:0] p);
    logic [3:0] v;
    v = 4'h0;
    for (int i = irrb_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (p[i]) begin
        v = 4'(i);
      end
    end
    return v;
  endfunction

  // holding register of a source; codes past the last source land on
  // primary 0 bit 7, which is not implemented, so a stray ack clears no flag
  function automatic logic [2:0] hold_reg(input logic [3:0] s);
    logic [2:0] r;
    r = irrb_pkg::IDX_PRI0;
    if (s < 4'(irrb_pkg::NUM_SRC)) begin
      r = irrb_pkg::SRC_REG[s];
    end
    return r;
  endfunction

  // flag bit of a source inside its holding register
  function automatic logic [2:0] flag_pos(input logic [3:0] s);
    logic [2:0] f;
    f = 3'h7;
    if (s < 4'(irrb_pkg::NUM_SRC)) begin
      f = irrb_pkg::SRC_FLAG[s];
    end
    return f;
  endfunction

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] ctl_reg  [0:irrb_pkg::NUM_REGS-1];
  logic [7:0] ctl_next [0:irrb_pkg::NUM_REGS-1];
  logic [7:0] set_vec  [0:irrb_pkg::NUM_REGS-1];
  logic [7:0] clr_vec  [0:irrb_pkg::NUM_REGS-1];

  logic [irrb_pkg::NUM_SRC-1:0] src_set;
  logic [irrb_pkg::NUM_SRC-1:0] pend;
  logic                         req_next;
  logic [3:0]                   vec_next;
  logic                         wake_next;
  logic [3:0]                   vec_reg;

  logic [1:0] pin_raw;
  logic [1:0] pin_now;
  logic [1:0] pin_prev;
  logic [1:0] pin_hit;

  assign pin_raw = {PIN1, PIN0};

  // ---------------------------------------------------------------
  // pin synchronisers and edge detect
  // ---------------------------------------------------------------
  // two external pins only
  for (genvar p = 0; p < 2; p++) begin : g_pin
    logic [SYNC_STAGES-1:0] sync_reg;

    // first stage feeds only the second stage
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        sync_reg <= '0;
      end else if (CE) begin
        sync_reg <= {sync_reg[SYNC_STAGES-2:0], pin_raw[p]};
      end
    end

    assign pin_now[p] = sync_reg[SYNC_STAGES-1];

    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        pin_prev[p] <= 1'b0;
      end else if (CE) begin
        pin_prev[p] <= pin_now[p];
      end
    end
  end

  // no start-up edge
  // hits ignored until synchronisers and previous-level flop hold real
  // levels; a pin idling high would otherwise look like a rising edge
  logic [SYNC_STAGES:0] prime_reg;
  logic                 primed;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      prime_reg <= '0;
    end else if (CE) begin
      prime_reg <= {prime_reg[SYNC_STAGES-1:0], 1'b1};
    end
  end

  assign primed = prime_reg[SYNC_STAGES];

  assign pin_hit[0] = primed & edge_hit(
    ctl_reg[irrb_pkg::IDX_EDGE][irrb_pkg::PIN0_SEL_LSB +: 2],
    pin_now[0], pin_prev[0]);
  assign pin_hit[1] = primed & edge_hit(
    ctl_reg[irrb_pkg::IDX_EDGE][irrb_pkg::PIN1_SEL_LSB +: 2],
    pin_now[1], pin_prev[1]);

  // ---------------------------------------------------------------
  // source set pulses
  // ---------------------------------------------------------------
  always_comb begin
    src_set = '0;
    src_set[irrb_pkg::V_PIN0]  = pin_hit[0];
    src_set[irrb_pkg::V_PIN1]  = pin_hit[1];
    src_set[irrb_pkg::V_ADC]   = PRI_EVT.adc;
    src_set[irrb_pkg::V_GRP0]  =
      |(GRP_EVT.grp0 & ctl_reg[irrb_pkg::IDX_GRP0][irrb_pkg::FIELD_W-1:0]);
    src_set[irrb_pkg::V_GRP1]  =
      |(GRP_EVT.grp1 & ctl_reg[irrb_pkg::IDX_GRP1][irrb_pkg::FIELD_W-1:0]);
    src_set[irrb_pkg::V_GRP2]  =
      |(GRP_EVT.grp2 & ctl_reg[irrb_pkg::IDX_GRP2][irrb_pkg::FIELD_W-1:0]);
    src_set[irrb_pkg::V_OVP]   = PRI_EVT.ovp;
    src_set[irrb_pkg::V_TB0]   = PRI_EVT.tb0;
    src_set[irrb_pkg::V_TB1]   = PRI_EVT.tb1;
    src_set[irrb_pkg::V_UART0] = PRI_EVT.uart0;
    src_set[irrb_pkg::V_SIM]   = PRI_EVT.sim;
    src_set[irrb_pkg::V_SPIA]  = PRI_EVT.spia;
    src_set[irrb_pkg::V_UART1] = PRI_EVT.uart1;
  end

  // ---------------------------------------------------------------
  // set and clear maps
  // ---------------------------------------------------------------
  always_comb begin
    for (int r = 0; r < irrb_pkg::NUM_REGS; r++) begin
      set_vec[r] = 8'h00;
      clr_vec[r] = 8'h00;
    end
    for (int i = 0; i < irrb_pkg::NUM_SRC; i++) begin
      set_vec[hold_reg(4'(i))][flag_pos(4'(i))] = src_set[i];
    end
    // member flags latch regardless of enables
    set_vec[irrb_pkg::IDX_GRP0][irrb_pkg::FLAG_LSB +: irrb_pkg::FIELD_W] =
      GRP_EVT.grp0;
    set_vec[irrb_pkg::IDX_GRP1][irrb_pkg::FLAG_LSB +: irrb_pkg::FIELD_W] =
      GRP_EVT.grp1;
    set_vec[irrb_pkg::IDX_GRP2][irrb_pkg::FLAG_LSB +: irrb_pkg::FIELD_W] =
      GRP_EVT.grp2;
    // vectoring clears flag and global enable
    if (IRQ_ACK) begin
      clr_vec[hold_reg(vec_reg)][flag_pos(vec_reg)] = 1'b1;
      clr_vec[irrb_pkg::IDX_PRI0][irrb_pkg::GIE_BIT] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // next register values
  // ---------------------------------------------------------------
  // write first, then clear, then set: a set in the same cycle wins
  always_comb begin
    for (int r = 0; r < irrb_pkg::NUM_REGS; r++) begin
      if (SFR_WR && (SFR_ADDR == 3'(r))) begin
        ctl_next[r] = SFR_WDATA;
      end else begin
        ctl_next[r] = ctl_reg[r];
      end
      ctl_next[r] = (ctl_next[r] & ~clr_vec[r]) | set_vec[r];
      // unimplemented bits of every register, such as bit 7 of primary register 0
      ctl_next[r] = ctl_next[r] & irrb_pkg::IMPL_MASK[r];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int r = 0; r < irrb_pkg::NUM_REGS; r++) begin
        ctl_reg[r] <= irrb_pkg::RESET_VAL;
      end
    end else if (CE) begin
      for (int r = 0; r < irrb_pkg::NUM_REGS; r++) begin
        ctl_reg[r] <= ctl_next[r];
      end
    end
  end

  // ---------------------------------------------------------------
  // vector request
  // ---------------------------------------------------------------
  // computed from next values so an ack drops the request at once
  always_comb begin
    for (int i = 0; i < irrb_pkg::NUM_SRC; i++) begin
      pend[i] =
        ctl_next[hold_reg(4'(i))][flag_pos(4'(i))] &
        ctl_next[hold_reg(4'(i))][irrb_pkg::SRC_BIT[i]];
    end
    req_next = ctl_next[irrb_pkg::IDX_PRI0][irrb_pkg::GIE_BIT] &
               (|pend) & ~STACK_FULL;
    vec_next = first_pending(pend);
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      IRQ_REQ <= 1'b0;
      vec_reg <= 4'h0;
    end else if (CE) begin
      IRQ_REQ <= req_next;
      vec_reg <= vec_next;
    end
  end

  assign IRQ_VEC = vec_reg;

  // ---------------------------------------------------------------
  // wake-up
  // ---------------------------------------------------------------
  // only a fresh 0 to 1 flag
  always_comb begin
    wake_next = 1'b0;
    for (int r = 0; r < irrb_pkg::NUM_REGS; r++) begin
      wake_next = wake_next |
        (|(set_vec[r] & ~ctl_reg[r] & irrb_pkg::IMPL_MASK[r] &
           irrb_pkg::FLAG_MASK));
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      WAKE <= 1'b0;
    end else if (CE) begin
      WAKE <= wake_next;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // one cycle of latency; reads have no side effects
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      SFR_RDATA <= 8'h00;
    end else if (CE) begin
      SFR_RDATA <= ctl_reg[SFR_ADDR];
    end
  end

endmodule

`default_nettype wire

// ===== tb/irrb_cpu_model.sv
// cpu-side partner: takes vectors after a chosen wait, reports stack full
// assumes the bank's request and vector are registered on clk
`timescale 1ns/1ps
`default_nettype none
module irrb_cpu_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       irq_req,
  input  wire logic [3:0] irq_vec,
  input  wire logic       auto_ack,
  input  wire logic [1:0] lat,
  input  wire logic       full,
  output logic            irq_ack,
  output logic            stack_full,
  output logic      [3:0] taken
);
  logic [1:0] wait_reg;
  logic       fire_reg;
  // ack gated by the live request so it is never offered to an idle bank
  assign irq_ack = fire_reg & irq_req;
  assign stack_full = full;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_reg <= 2'h0;
      fire_reg <= 1'b0;
      taken <= 4'h0;
    end else begin
      fire_reg <= 1'b0;
      if (irq_ack)
        taken <= irq_vec;
      if (!(irq_req && auto_ack) || irq_ack || fire_reg)
        wait_reg <= 2'h0;
      else if (wait_reg == lat)
        fire_reg <= 1'b1;
      else
        wait_reg <= wait_reg + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ===== tb/irrb_monitor.sv
// checker for irrb_top, bound onto its ports
// assumes one CLK domain and asynchronous active-high RST
`timescale 1ns/1ps
`default_nettype none
module irrb_monitor #(
  parameter int SYNC_STAGES = 2
) (
  input wire logic                    CLK,
  input wire logic                    RST,
  input wire logic                    CE,
  input wire logic [2:0]              SFR_ADDR,
  input wire logic                    SFR_WR,
  input wire logic [7:0]              SFR_WDATA,
  input wire logic [7:0]              SFR_RDATA,
  input wire logic                    PIN0,
  input wire logic                    PIN1,
  input wire irrb_pkg::irrb_pri_evt_s PRI_EVT,
  input wire irrb_pkg::irrb_grp_evt_s GRP_EVT,
  input wire logic                    STACK_FULL,
  input wire logic                    IRQ_ACK,
  input wire logic                    IRQ_REQ,
  input wire logic [3:0]              IRQ_VEC,
  input wire logic                    WAKE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // ----
  // helpers
  // ----
  // pins need the sync depth plus one before a flag can move
  logic [2:0] quiet_reg;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST)
      quiet_reg <= 3'h0;
    else if (|PRI_EVT || |GRP_EVT || SFR_WR || !$stable(PIN0) || !$stable(PIN1))
      quiet_reg <= 3'h0;
    else if (quiet_reg != 3'h7)
      quiet_reg <= quiet_reg + 3'h1;
  end
  sequence wr_at(logic [2:0] a);
    CE && SFR_WR && SFR_ADDR == a;
  endsequence
  sequence rd_at(logic [2:0] a);
    CE && !SFR_WR && SFR_ADDR == a;
  endsequence
  property zero_bits(logic [2:0] a, logic [7:0] m);
    CE && SFR_ADDR == a |=> (SFR_RDATA & m) == 8'h00;
  endproperty
  // ----
  // assertions
  // ----
  // edge readback
  edge_readback_a: assert property (
    wr_at(3'h0) ##1 rd_at(3'h0) |=> SFR_RDATA == ($past(SFR_WDATA, 2) & 8'h0f))
    else $error("edge select readback wrong");
  edge_high_zero_a: assert property (zero_bits(3'h0, 8'hf0))
    else $error("edge select high bits not zero");
  pri0_top_zero_a: assert property (zero_bits(3'h1, 8'h80))
    else $error("primary 0 bit 7 not zero");
  pri3_unused_a: assert property (zero_bits(3'h4, 8'hcc))
    else $error("primary 3 unused bits not zero");
  grp2_unused_a: assert property (zero_bits(3'h7, 8'hcc))
    else $error("grouped 2 unused bits not zero");
  reset_quiet_a: assert property (disable iff (1'b0)
    RST |-> !IRQ_REQ && !WAKE && SFR_RDATA == 8'h00 && IRQ_VEC == 4'h0)
    else $error("outputs not cleared in reset");
  vec_range_a: assert property (IRQ_REQ |-> IRQ_VEC <= 4'hc)
    else $error("vector index out of range");
  ack_clears_a: assert property (CE && IRQ_ACK && !SFR_WR |=> !IRQ_REQ)
    else $error("request stays after acknowledge");
  full_block_a: assert property (CE && STACK_FULL |=> !IRQ_REQ)
    else $error("request raised while stack full");
  wake_quiet_a: assert property (quiet_reg > 3'(SYNC_STAGES + 1) |-> !WAKE)
    else $error("wake without a new flag");
endmodule
bind irrb_top irrb_monitor #(.SYNC_STAGES(SYNC_STAGES)) u_mon (
  .CLK(CLK), .RST(RST), .CE(CE), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
  .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .PIN0(PIN0), .PIN1(PIN1),
  .PRI_EVT(PRI_EVT), .GRP_EVT(GRP_EVT), .STACK_FULL(STACK_FULL), .IRQ_ACK(IRQ_ACK),
  .IRQ_REQ(IRQ_REQ), .IRQ_VEC(IRQ_VEC), .WAKE(WAKE));
`default_nettype wire

// ===== tb/test_irrb_top.sv
// bench for irrb_top: registers, events, vectoring, pin edges
// assumes irrb_cpu_model on the far side for acks and stack full
`timescale 1ns/1ps
`default_nettype none
module test_irrb_top;
  logic                    clk;
  logic                    rst;
  logic                    ce;
  logic                    wr_en;
  logic                    pin0;
  logic                    pin1;
  logic                    full;
  logic                    auto_ack;
  logic                    irq_ack;
  logic                    stack_full;
  logic                    irq_req;
  logic                    wake;
  logic [1:0]              lat;
  logic [2:0]              addr;
  logic [3:0]              vec;
  logic [3:0]              taken;
  logic [7:0]              wdata;
  logic [7:0]              rdata;
  logic [15:0]             lfsr;
  irrb_pkg::irrb_pri_evt_s pri_evt;
  irrb_pkg::irrb_grp_evt_s grp_evt;
  int                      n_fail;
  int                      compares;
  irrb_top u_dut (.CLK(clk), .RST(rst), .CE(ce), .SFR_ADDR(addr), .SFR_WR(wr_en),
    .SFR_WDATA(wdata), .SFR_RDATA(rdata), .PIN0(pin0), .PIN1(pin1), .PRI_EVT(pri_evt),
    .GRP_EVT(grp_evt), .STACK_FULL(stack_full), .IRQ_ACK(irq_ack), .IRQ_REQ(irq_req),
    .IRQ_VEC(vec), .WAKE(wake));
  irrb_cpu_model u_cpu (.clk(clk), .rst(rst), .irq_req(irq_req), .irq_vec(vec),
    .auto_ack(auto_ack), .lat(lat), .full(full), .irq_ack(irq_ack),
    .stack_full(stack_full), .taken(taken));
  // ----
  // helpers
  // ----
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] exp_vec(input irrb_pkg::irrb_pri_evt_s e);
    if (e.adc) return 8'h02;
    if (e.ovp) return 8'h06;
    if (e.tb0) return 8'h07;
    if (e.tb1) return 8'h08;
    if (e.uart0) return 8'h09;
    if (e.sim) return 8'h0a;
    if (e.spia) return 8'h0b;
    return 8'h0c;
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_en <= 1'b1;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // read data lags the address by one edge
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    #1 chk(rdata, e);
  endtask
  task automatic pulse(input irrb_pkg::irrb_pri_evt_s p, input logic [11:0] g);
    @(posedge clk);
    pri_evt <= p;
    grp_evt <= g;
    @(posedge clk);
    pri_evt <= '0;
    grp_evt <= '0;
    #1;
  endtask
  task automatic pins(input logic v);
    @(posedge clk);
    pin0 <= v;
    pin1 <= v;
    repeat (5) @(posedge clk);
  endtask
  task automatic wait_ack;
    int k;
    k = 0;
    while (irq_ack !== 1'b1 && k < 40) begin
      @(posedge clk);
      #1 k++;
    end
    chk({7'h0, irq_ack}, 8'h01);
    @(posedge clk);
    #1;
  endtask
  // ----
  // stimulus
  // ----
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    addr = 3'h0;
    wr_en = 1'b0;
    wdata = 8'h00;
    pin0 = 1'b0;
    pin1 = 1'b0;
    pri_evt = '0;
    grp_evt = '0;
    auto_ack = 1'b0;
    full = 1'b0;
    lat = 2'h0;
    lfsr = 16'h6c51;
    n_fail = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rc(i[2:0], 8'h00);
      wr(i[2:0], 8'hff);
      rc(i[2:0], irrb_pkg::IMPL_MASK[i]);
      lfsr = nxt(lfsr);
      wr(i[2:0], lfsr[7:0]);
      rc(i[2:0], lfsr[7:0] & irrb_pkg::IMPL_MASK[i]);
      wr(i[2:0], 8'h00);
    end
    wr(3'h1, 8'h09);
    pulse(8'h80, 12'h000);
    chk({7'h0, irq_req}, 8'h01);
    chk({4'h0, vec}, 8'h02);
    chk({7'h0, wake}, 8'h01);
    lat <= lfsr[1:0];
    auto_ack <= 1'b1;
    wait_ack();
    chk({4'h0, taken}, 8'h02);
    rc(3'h1, 8'h08);
    pulse(8'h80, 12'h000);
    chk({7'h0, irq_req}, 8'h00);
    chk({7'h0, wake}, 8'h01);
    pulse(8'h80, 12'h000);
    chk({7'h0, wake}, 8'h00);
    rc(3'h1, 8'h48);
    full <= 1'b1;
    wr(3'h1, 8'h49);
    repeat (3) @(posedge clk);
    #1 chk({7'h0, irq_req}, 8'h00);
    full <= 1'b0;
    wait_ack();
    rc(3'h1, 8'h08);
    auto_ack <= 1'b0;
    repeat (8) begin
      lfsr = nxt(lfsr);
      wr(3'h1, 8'h09);
      wr(3'h2, 8'h08);
      wr(3'h3, 8'h0f);
      wr(3'h4, 8'h03);
      pulse(lfsr[7:0] | 8'h01, 12'h000);
      chk({4'h0, vec}, exp_vec(lfsr[7:0] | 8'h01));
    end
    wr(3'h5, 8'h01);
    wr(3'h2, 8'h01);
    wr(3'h1, 8'h01);
    pulse(8'h00, 12'h003);
    chk({4'h0, vec}, 8'h03);
    rc(3'h5, 8'h31);
    rc(3'h2, 8'h11);
    for (int c = 0; c < 4; c++) begin
      wr(3'h0, {4'h0, c[1:0], c[1:0]});
      wr(3'h1, 8'h00);
      pins(1'b1);
      rc(3'h1, {2'h0, c[0], c[0], 4'h0});
      wr(3'h1, 8'h00);
      pins(1'b0);
      rc(3'h1, {2'h0, c[1], c[1], 4'h0});
    end
    // clock enable low: an event pulse must leave the flags alone
    ce <= 1'b0;
    pulse(8'h80, 12'h000);
    ce <= 1'b1;
    rc(3'h1, 8'h30);
    close_out();
  end
endmodule
`default_nettype wire
